// File: manual_override_input_control.sv
/*
 * Mode controller: bus or manual operation, input freeze, LEDs, inhibit,
 * periodic send and programming indicator.
 * Assumes all inputs are synchronous and debounced; the bus stack consumes
 * one-cycle send requests and the cyclic timer pulse comes from elsewhere.
 */
`timescale 1ns/10ps

// Behaviour
// - Power up in bus mode, mode LED off.
// - Bus mode: LEDs show live inputs, keys ignored.
// - Mode toggles only after two-second hold.
// - Manual entry latches inputs; terminals ignored.
// - Manual key changes still send telegrams.
// - Manual exit restores live inputs and sends.
// - Manual not enabled: button does nothing.
// - Manual disabled: LED flashes three seconds.
// - Inhibit disconnects input from evaluation.
// - Inhibited input still sent periodically.
// - Inhibit has no effect in manual mode.
// - Programming LED toggles, clears on address.
// - Default address holds until programmed.
module manual_override_input_control #(
    parameter int LONG_PRESS_CYCLES = manual_pkg::LONG_PRESS_CYC,
    parameter int FLASH_CYCLES = manual_pkg::FLASH_CYC,
    parameter int FLASH_HALF_CYCLES = manual_pkg::FLASH_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [manual_pkg::N_INPUTS-1:0] phys_in,
    input wire logic [manual_pkg::N_INPUTS-1:0] key_in,
    input wire logic mode_btn,
    input wire logic prog_btn,
    input wire logic manual_enabled,
    input wire logic manual_disabled,
    input wire logic [manual_pkg::N_INPUTS-1:0] inhibit,
    input wire logic [manual_pkg::N_INPUTS-1:0] cyclic_en,
    input wire logic cyclic_tick,
    input wire logic addr_wr,
    input wire logic [15:0] addr_in,
    output logic [15:0] bus_addr,
    output manual_pkg::tx_req_t tx_req,
    output manual_pkg::led_t leds,
    output logic manual_active
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    manual_pkg::op_mode_t mode_q, mode_d;
    manual_pkg::btn_state_t btn_q, btn_d;
    logic [manual_pkg::CNT_W-1:0] press_q, press_d;
    logic [manual_pkg::CNT_W-1:0] flash_q, flash_d;
    logic [manual_pkg::CNT_W-1:0] half_q, half_d;
    logic blink_q, blink_d;
    logic mled_q, mled_d;
    logic prog_q, prog_d;
    logic prog_prev_q;
    logic [15:0] addr_q, addr_d;
    logic [manual_pkg::N_INPUTS-1:0] man_q, man_d;
    logic [manual_pkg::N_INPUTS-1:0] eval_q, eval_d;
    logic [manual_pkg::N_INPUTS-1:0] key_prev_q;
    manual_pkg::tx_req_t tx_q, tx_d;
    manual_pkg::led_t leds_q, leds_d;

    // ---------------------------------------------------------------
    // Mode button and mode
    // ---------------------------------------------------------------
    always_comb
    begin
        mode_d = mode_q;
        btn_d = btn_q;
        press_d = press_q;
        flash_d = flash_q;
        half_d = half_q;
        blink_d = blink_q;
        mled_d = mled_q;
        if (flash_q != '0)
        begin
            flash_d = flash_q - 1'b1;
            if (half_q == '0)
            begin
                half_d = manual_pkg::CNT_W'(FLASH_HALF_CYCLES - 1);
                blink_d = ~blink_q;
            end
            else
            begin
                half_d = half_q - 1'b1;
            end
            if (flash_q == manual_pkg::CNT_W'(1))
            begin
                mled_d = ~mled_q;
            end
        end
        unique case (btn_q)
            manual_pkg::BTN_IDLE:
            begin
                if (mode_btn && manual_enabled)
                begin
                    btn_d = manual_pkg::BTN_TIMING;
                    press_d = '0;
                end
            end
            manual_pkg::BTN_TIMING:
            begin
                if (!mode_btn)
                begin
                    btn_d = manual_pkg::BTN_IDLE;
                end
                else if (press_q == manual_pkg::CNT_W'(LONG_PRESS_CYCLES - 1))
                begin
                    btn_d = manual_pkg::BTN_HELD;
                    if (manual_disabled)
                    begin
                        flash_d = manual_pkg::CNT_W'(FLASH_CYCLES);
                        half_d = manual_pkg::CNT_W'(FLASH_HALF_CYCLES - 1);
                        blink_d = 1'b1;
                    end
                    else if (mode_q == manual_pkg::OPM_BUS)
                    begin
                        mode_d = manual_pkg::OPM_MANUAL;
                        mled_d = 1'b1;
                    end
                    else
                    begin
                        mode_d = manual_pkg::OPM_BUS;
                        mled_d = 1'b0;
                    end
                end
                else
                begin
                    press_d = press_q + 1'b1;
                end
            end
            manual_pkg::BTN_HELD:
            begin
                if (!mode_btn)
                begin
                    btn_d = manual_pkg::BTN_IDLE;
                end
            end
            default:
            begin
                btn_d = manual_pkg::BTN_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= manual_pkg::OPM_BUS;
            btn_q <= manual_pkg::BTN_IDLE;
            press_q <= '0;
            flash_q <= '0;
            half_q <= '0;
            blink_q <= 1'b0;
            mled_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            btn_q <= btn_d;
            press_q <= press_d;
            flash_q <= flash_d;
            half_q <= half_d;
            blink_q <= blink_d;
            mled_q <= mled_d;
        end
    end

    // ---------------------------------------------------------------
    // Inputs, inhibit and telegrams
    // ---------------------------------------------------------------
    always_comb
    begin
        logic entering;
        logic leaving;
        entering = (mode_q == manual_pkg::OPM_BUS) && (mode_d == manual_pkg::OPM_MANUAL);
        leaving = (mode_q == manual_pkg::OPM_MANUAL) && (mode_d == manual_pkg::OPM_BUS);
        man_d = man_q;
        eval_d = eval_q;
        tx_d = '0;
        if (entering)
        begin
            man_d = eval_q;
        end
        else if (mode_q == manual_pkg::OPM_MANUAL)
        begin
            // Keys act on rising edge; inhibit is deliberately not consulted.
            man_d = man_q ^ (key_in & ~key_prev_q);
            tx_d.valid = man_d ^ man_q;
            tx_d.state = man_d;
        end
        if (leaving)
        begin
            eval_d = phys_in;
            tx_d.valid = '1;
            tx_d.state = phys_in;
        end
        else if (mode_q == manual_pkg::OPM_BUS)
        begin
            // Inhibited inputs freeze their last valid state.
            eval_d = (phys_in & ~inhibit) | (eval_q & inhibit);
            tx_d.valid = (eval_d ^ eval_q);
            tx_d.state = eval_d;
        end
        if (cyclic_tick && !leaving)
        begin
            tx_d.valid = tx_d.valid | cyclic_en;
            tx_d.state = (mode_q == manual_pkg::OPM_MANUAL) ? man_d : eval_d;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            man_q <= '0;
            eval_q <= '0;
            key_prev_q <= '0;
            tx_q <= '0;
        end
        else
        begin
            man_q <= man_d;
            eval_q <= eval_d;
            key_prev_q <= key_in;
            tx_q <= tx_d;
        end
    end

    // ---------------------------------------------------------------
    // Programming and address
    // ---------------------------------------------------------------
    always_comb
    begin
        prog_d = prog_q;
        addr_d = addr_q;
        if (prog_btn && !prog_prev_q)
        begin
            prog_d = ~prog_q;
        end
        if (addr_wr)
        begin
            addr_d = addr_in;
            prog_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_q <= 1'b0;
            prog_prev_q <= 1'b0;
            addr_q <= manual_pkg::DEFAULT_ADDR;
        end
        else
        begin
            prog_q <= prog_d;
            prog_prev_q <= prog_btn;
            addr_q <= addr_d;
        end
    end

    // ---------------------------------------------------------------
    // Indicators
    // ---------------------------------------------------------------
    always_comb
    begin
        leds_d.prog = prog_d;
        leds_d.mode = (flash_d != '0) ? blink_d : mled_d;
        // Bus mode shows the live terminals, even under inhibit.
        leds_d.inputs = (mode_d == manual_pkg::OPM_MANUAL) ? man_d : phys_in;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            leds_q <= '0;
        end
        else
        begin
            leds_q <= leds_d;
        end
    end

    assign leds = leds_q;
    assign tx_req = tx_q;
    assign bus_addr = addr_q;
    assign manual_active = (mode_q == manual_pkg::OPM_MANUAL);
endmodule : manual_override_input_control

// File: manual_pkg.sv
/*
 * Constants and carrier types for the manual override input controller.
 * Assumes a single 25 MHz core clock and eight binary inputs.
 */
package manual_pkg;
    // ---------------------------------------------------------------
    // Sizes and timing
    // ---------------------------------------------------------------
    localparam int N_INPUTS = 8;
    localparam int CLK_HZ = 25000000;
    localparam int LONG_PRESS_MS = 2000;
    localparam int FLASH_MS = 3000;
    localparam int LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
    localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam int CNT_W = 28;
    // ---------------------------------------------------------------
    // Bus address and object numbers
    // ---------------------------------------------------------------
    localparam logic [15:0] DEFAULT_ADDR = 16'hffff; // Area 15, line 15, device 255.
    localparam logic [7:0] INHIBIT_OBJ = 8'h0a;

    typedef enum logic [1:0] {OPM_BUS, OPM_MANUAL} op_mode_t;
    typedef enum logic [1:0] {BTN_IDLE, BTN_TIMING, BTN_HELD} btn_state_t;

    typedef struct packed {
        logic [N_INPUTS-1:0] valid;
        logic [N_INPUTS-1:0] state;
    } tx_req_t;

    typedef struct packed {
        logic mode;
        logic prog;
        logic [N_INPUTS-1:0] inputs;
    } led_t;
endpackage : manual_pkg

// File: manual_asserts.sv
/* Port checker for the mode controller.
   Assumes one clock domain and the bind at the foot. */
`timescale 1ns/10ps
module manual_asserts #(
    parameter int LONG_PRESS_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] phys_in,
    input wire logic [7:0] key_in,
    input wire logic mode_btn,
    input wire logic prog_btn,
    input wire logic manual_enabled,
    input wire logic manual_disabled,
    input wire logic [7:0] inhibit,
    input wire logic [7:0] cyclic_en,
    input wire logic cyclic_tick,
    input wire logic addr_wr,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] bus_addr,
    input wire manual_pkg::tx_req_t tx_req,
    input wire manual_pkg::led_t leds,
    input wire logic manual_active
);
    logic [27:0] hold_q;
    logic [27:0] hold_d;
    // Saturates so that a stuck button never wraps into a false match.
    always_comb
    begin
        hold_d = hold_q;
        if (!mode_btn)
            hold_d = 28'h0;
        else if (!(&hold_q))
            hold_d = hold_q + 28'h1;
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            hold_q <= 28'h0;
        else
            hold_q <= hold_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence key_rise_s;
        manual_active && $rose(key_in[0]);
    endsequence
    sequence quiet_s;
        manual_active && $stable(key_in) ##1 manual_active;
    endsequence
    mode_toggle_a: assert property (
        $changed(manual_active) |-> $past(hold_q) == LONG_PRESS_CYCLES
        && $past(manual_enabled) && !$past(manual_disabled))
        else $error("mode change without one exact long press");
    live_leds_a: assert property (
        !manual_active ##1 !manual_active |-> leds.inputs == $past(phys_in))
        else $error("bus mode input leds not live");
    frozen_a: assert property (quiet_s |-> $stable(leds.inputs))
        else $error("manual input leds moved without a key");
    key_send_a: assert property (key_rise_s |=> tx_req.valid[0]
        && tx_req.state[0] == leds.inputs[0] && $changed(leds.inputs[0]))
        else $error("manual key did not toggle and send");
    exit_send_a: assert property ($fell(manual_active) |->
        tx_req.valid == 8'hff && tx_req.state == $past(phys_in))
        else $error("manual exit did not send live inputs");
    inhibit_a: assert property (
        inhibit == 8'hff && !cyclic_tick && !manual_active ##1 !manual_active
        |-> tx_req.valid == 8'h00)
        else $error("inhibited inputs sent an event");
    cyclic_a: assert property (cyclic_tick |=>
        (tx_req.valid & $past(cyclic_en)) == $past(cyclic_en))
        else $error("cyclic send missing");
    addr_load_a: assert property (addr_wr |=>
        bus_addr == $past(addr_in) && !leds.prog)
        else $error("address load wrong");
    addr_hold_a: assert property (!addr_wr |=> $stable(bus_addr))
        else $error("address moved without a write");
    prog_toggle_a: assert property (
        $rose(prog_btn) && !addr_wr |=> $changed(leds.prog))
        else $error("programming led did not toggle");
endmodule : manual_asserts
bind manual_override_input_control manual_asserts #(
    .LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)
) chk_u (.core_clk, .resetn, .phys_in, .key_in, .mode_btn, .prog_btn,
    .manual_enabled, .manual_disabled, .inhibit, .cyclic_en, .cyclic_tick,
    .addr_wr, .addr_in, .bus_addr, .tx_req, .leds, .manual_active);

// File: kbus_sink.sv
/* Model of the bus stack that takes send requests.
   Assumes one-cycle request pulses on the core clock. */
`timescale 1ns/10ps
module kbus_sink (
    input wire logic core_clk,
    input wire logic resetn,
    input wire manual_pkg::tx_req_t tx_req,
    output logic [15:0] count,
    output logic [7:0] last_valid,
    output logic [7:0] last_state
);
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 16'h0;
            last_valid <= 8'h0;
            last_state <= 8'h0;
        end
        else if (tx_req.valid != 8'h0)
        begin
            count <= count + 16'h1;
            last_valid <= tx_req.valid;
            last_state <= tx_req.state & tx_req.valid;
        end
    end
endmodule : kbus_sink

// File: tb_manual_override_input_control.sv
/* Self-checking bench for the mode controller.
   Assumes short counts: hold 8, flash 12, half period 2. */
`timescale 1ns/10ps
module tb_manual_override_input_control;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] phys_in = 8'h0;
    logic [7:0] key_in = 8'h0;
    logic mode_btn = 1'b0;
    logic prog_btn = 1'b0;
    logic manual_enabled = 1'b1;
    logic manual_disabled = 1'b0;
    logic [7:0] inhibit = 8'h0;
    logic [7:0] cyclic_en = 8'h0;
    logic cyclic_tick = 1'b0;
    logic addr_wr = 1'b0;
    logic [15:0] addr_in = 16'h0;
    logic [15:0] bus_addr;
    manual_pkg::tx_req_t tx_req;
    manual_pkg::led_t leds;
    logic manual_active;
    logic [15:0] count;
    logic [7:0] last_valid;
    logic [7:0] last_state;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [15:0] c0;
    manual_override_input_control #(.LONG_PRESS_CYCLES(8), .FLASH_CYCLES(12),
        .FLASH_HALF_CYCLES(2)) dut_u (.core_clk, .resetn, .phys_in, .key_in,
        .mode_btn, .prog_btn, .manual_enabled, .manual_disabled, .inhibit,
        .cyclic_en, .cyclic_tick, .addr_wr, .addr_in, .bus_addr, .tx_req,
        .leds, .manual_active);
    kbus_sink sink_u (.core_clk, .resetn, .tx_req, .count, .last_valid,
        .last_state);
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end
    task tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tk
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task press(input int n);
        @(posedge core_clk) mode_btn <= 1'b1;
        tk(n);
        @(posedge core_clk) mode_btn <= 1'b0;
        tk(2);
    endtask : press
    task key(input int i);
        @(posedge core_clk) key_in[i] <= 1'b1;
        tk(2);
        @(posedge core_clk) key_in[i] <= 1'b0;
        tk(2);
    endtask : key
    task pulse_prog();
        @(posedge core_clk) prog_btn <= 1'b1;
        @(posedge core_clk) prog_btn <= 1'b0;
        tk(2);
    endtask : pulse_prog
    task final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // The whole run needs some 180 cycles; the ceiling leaves ample margin.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        tk(2);
        chk(bus_addr, 16'hffff);
        chk({leds.mode, manual_active}, 16'h0);
        $display("test power-up done");
        @(posedge core_clk) phys_in <= 8'h5a;
        key_in <= 8'hff;
        tk(3);
        chk(leds.inputs, 16'h5a);
        @(posedge core_clk) key_in <= 8'h0;
        press(6);
        chk(manual_active, 16'h0);
        press(20);
        chk({leds.mode, manual_active}, 16'h3);
        @(posedge core_clk) phys_in <= 8'h0;
        tk(3);
        chk(leds.inputs, 16'h5a);
        key(0);
        chk(leds.inputs, 16'h5b);
        chk({last_valid, last_state}, 16'h0101);
        @(posedge core_clk) inhibit <= 8'hff;
        key(1);
        chk(leds.inputs, 16'h59);
        chk({last_valid, last_state}, 16'h0200);
        press(12);
        chk({leds.mode, manual_active, leds.inputs}, 16'h0);
        chk({last_valid, last_state}, 16'hff00);
        $display("test manual done");
        c0 = count;
        @(posedge core_clk) phys_in <= 8'h33;
        cyclic_en <= 8'h0f;
        tk(3);
        chk(count, c0);
        chk(leds.inputs, 16'h33);
        @(posedge core_clk) cyclic_tick <= 1'b1;
        @(posedge core_clk) cyclic_tick <= 1'b0;
        tk(2);
        chk({last_valid, last_state}, 16'h0f00);
        $display("test inhibit done");
        @(posedge core_clk) manual_enabled <= 1'b0;
        inhibit <= 8'h0;
        tk(1);
        press(12);
        chk({leds.mode, manual_active}, 16'h0);
        @(posedge core_clk) manual_enabled <= 1'b1;
        manual_disabled <= 1'b1;
        tk(1);
        press(10);
        chk(leds.mode, 16'h1);
        tk(2);
        chk(leds.mode, 16'h0);
        tk(28);
        chk({leds.mode, manual_active}, 16'h2);
        $display("test config done");
        pulse_prog();
        chk(leds.prog, 16'h1);
        pulse_prog();
        chk(leds.prog, 16'h0);
        pulse_prog();
        @(posedge core_clk) addr_wr <= 1'b1;
        addr_in <= 16'h1234;
        @(posedge core_clk) addr_wr <= 1'b0;
        tk(2);
        chk(bus_addr, 16'h1234);
        chk(leds.prog, 16'h0);
        $display("test address done");
        final_report();
    end
endmodule : tb_manual_override_input_control
